/* hw/itse_pkg.sv */
/*
 * Constants for the I/O, timer-skip, serial and clock instruction executer:
 * instruction codes, register offsets, field positions and reset values.
 * Assumes a 10-bit instruction word and a 4-bit accumulator datapath.
 */
`default_nettype none

package itse_pkg;

    // ----------------------------------------------------------------
    // instruction codes
    // ----------------------------------------------------------------
    localparam logic [9:0] OP_SKIP_T1 = 10'h280;
    localparam logic [9:0] OP_SKIP_T2 = 10'h281;
    localparam logic [9:0] OP_SKIP_T3 = 10'h282;
    localparam logic [9:0] OP_SKIP_T4 = 10'h283;
    localparam logic [9:0] OP_IN_BASE = 10'h260;
    localparam logic [9:0] OP_OUT_BASE = 10'h220;
    localparam logic [9:0] OP_SET_ALL = 10'h011;
    localparam logic [9:0] OP_CLR_BIT = 10'h014;
    localparam logic [9:0] OP_SET_BIT = 10'h015;
    localparam logic [9:0] OP_TEST_BIT = 10'h024;
    localparam logic [9:0] OP_RD_PULL0 = 10'h257;
    localparam logic [9:0] OP_WR_PULL0 = 10'h22D;
    localparam logic [9:0] OP_RD_PULL1 = 10'h25E;
    localparam logic [9:0] OP_WR_PULL1 = 10'h22E;
    localparam logic [9:0] OP_RD_KW0 = 10'h256;
    localparam logic [9:0] OP_WR_KW0 = 10'h21B;
    localparam logic [9:0] OP_RD_KW1 = 10'h259;
    localparam logic [9:0] OP_WR_KW1 = 10'h214;
    localparam logic [9:0] OP_RD_KW2 = 10'h25A;
    localparam logic [9:0] OP_WR_KW2 = 10'h215;
    localparam logic [9:0] OP_WR_FMT0 = 10'h228;
    localparam logic [9:0] OP_WR_FMT1 = 10'h229;
    localparam logic [9:0] OP_WR_FMT2 = 10'h22A;
    localparam logic [9:0] OP_WR_FMT3 = 10'h22B;
    localparam logic [9:0] OP_SI_READ = 10'h278;
    localparam logic [9:0] OP_SI_WRITE = 10'h238;
    localparam logic [9:0] OP_SERIAL_START = 10'h29E;
    localparam logic [9:0] OP_SERIAL_SKIP = 10'h288;
    localparam logic [9:0] OP_RD_SCTL = 10'h242;
    localparam logic [9:0] OP_WR_SCTL = 10'h202;
    localparam logic [9:0] OP_SEL_CERAMIC = 10'h29A;
    localparam logic [9:0] OP_SEL_RC = 10'h29B;
    localparam logic [9:0] OP_SEL_CRYSTAL = 10'h29D;
    localparam logic [9:0] OP_WR_CCB = 10'h209;
    localparam logic [9:0] OP_RD_MODE = 10'h252;
    localparam logic [9:0] OP_WR_MODE = 10'h216;
    localparam logic [2:0] PORT_NONE = 3'h7;
    localparam logic [2:0] PORT_THREE_BIT = 3'h2;
    localparam logic [2:0] PORT_TWO_BIT = 3'h3;

    // ----------------------------------------------------------------
    // interrupt enable bit positions
    // ----------------------------------------------------------------
    localparam int IE1_T1 = 2;
    localparam int IE1_T2 = 3;
    localparam int IE2_T3 = 0;
    localparam int IE2_T4 = 1;
    localparam int IE2_SER = 3;

    // ----------------------------------------------------------------
    // bus register map and fields
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_IRQ_EN = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_CLOCK = 4'h8;
    localparam logic [3:0] ADDR_BIT_PORT = 4'hC;
    localparam int CLK_F_SEL = 0;
    localparam int CLK_F_CCB = 2;
    localparam int CLK_F_MODE = 4;
    localparam int STAT_F_SER = 4;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic [7:0] RST_BIT_PORT = 8'h00;
    localparam logic [7:0] RST_SHIFT = 8'h00;

    typedef enum logic [1:0] {
        ITSE_CLK_CERAMIC = 2'b00,
        ITSE_CLK_RC = 2'b01,
        ITSE_CLK_CRYSTAL = 2'b10
    } itse_clk_sel_e;

endpackage : itse_pkg

`default_nettype wire

/* hw/itse_core.sv */
/*
 * Executes the timer-skip, port I/O, bit-port, pull-up, key-wakeup, output
 * format, serial and clock-select instructions of a 4-bit core.
 * Assumes the sequencer presents one instruction word per cycle with its
 * A, B and Y values on the same clock, and consumes acc/b/skip one cycle
 * later. Port pins are asynchronous and synchronised here.
 */
// Register access over Avalon-MM and the register addresses were left to the implementer.
// Summary of operation
// - timer-one skip test: enable bit clear and flag set, skip and clear flag
// - timer-two skip test: enable bit clear and flag set, skip and clear flag
// - timer-three skip test: enable bit clear and flag set, skip and clear flag
// - timer-four skip test: enable bit clear and flag set, skip and clear flag
// - port input copies selected port pins into accumulator
// - port output writes accumulator into selected port latch
// - three-bit port: input clears acc bit 3, output writes three bits
// - two-bit port: moves only accumulator bits 1 and 0
// - set-all drives every bit-port line high in one cycle
// - bit-clear zeroes bit-port line chosen by pointer 0 to 7
// - bit-set raises bit-port line chosen by pointer, others unchanged
// - bit-test skips when selected line is zero
// - both pull-up registers read and written through accumulator
// - shift register high nibble with B, low nibble with accumulator
// - serial start clears completion flag and starts transfer
// - serial skip test: enable clear and flag set, skip and clear flag
// - three key-wakeup registers read and written through accumulator
// - four output format registers are write-only from accumulator
// - three instructions select ceramic, RC or crystal main clock
`default_nettype none

module itse_core
    import itse_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic [9:0] instr,
    input wire logic [3:0] acc_in,
    input wire logic [3:0] breg_in,
    input wire logic [2:0] y_ptr,
    input wire logic [3:0] timer_event,
    input wire logic serial_done_event,
    input wire logic [3:0] p0_pin,
    input wire logic [3:0] p1_pin,
    input wire logic [2:0] three_bit_pin,
    input wire logic [1:0] two_bit_pin,
    input wire logic [3:0] p4_pin,
    input wire logic [3:0] p5_pin,
    input wire logic [3:0] p6_pin,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [3:0] acc_out,
    output logic acc_we,
    output logic [3:0] breg_out,
    output logic breg_we,
    output logic skip,
    output logic serial_start,
    output logic [3:0] p0_latch,
    output logic [3:0] p1_latch,
    output logic [2:0] three_bit_port,
    output logic [1:0] two_bit_port,
    output logic [3:0] p4_latch,
    output logic [3:0] p5_latch,
    output logic [3:0] p6_latch,
    output logic [7:0] bit_port,
    output logic [3:0] pullup_control_zero,
    output logic [3:0] pullup_control_one,
    output logic [3:0] key_wake_control_zero,
    output logic [3:0] key_wake_control_one,
    output logic [3:0] key_wake_control_two,
    output logic [3:0] output_format_zero,
    output logic [3:0] output_format_one,
    output logic [3:0] output_format_two,
    output logic [3:0] output_format_three,
    output logic [7:0] serial_shift,
    output logic [3:0] serial_control_register,
    output logic [1:0] clock_select,
    output logic clock_control_bit_register,
    output logic [3:0] clock_mode_register
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] port_of(input logic [9:0] word, input logic [9:0] base);
        port_of = (word[9:3] == base[9:3]) ? word[2:0] : PORT_NONE;
    endfunction : port_of

    function automatic logic [3:0] pin_nibble(input logic [2:0] idx, input logic [24:0] pins);
        logic [3:0] val;
        val = 4'h0;
        case (idx)
            3'h0: val = pins[3:0];
            3'h1: val = pins[7:4];
            3'h2: val = {1'b0, pins[10:8]};
            3'h3: val = {2'b00, pins[12:11]};
            3'h4: val = pins[16:13];
            3'h5: val = pins[20:17];
            3'h6: val = pins[24:21];
            default: val = 4'h0;
        endcase
        pin_nibble = val;
    endfunction : pin_nibble

    logic go;
    logic [3:0] irq_en1;
    logic [3:0] irq_en2;
    logic [3:0] timer_flag;
    logic serial_done_flag;
    logic [24:0] pin_meta;
    logic [24:0] pin_sync;
    logic [2:0] in_port;
    logic [2:0] out_port;
    logic [3:0] timer_skip_en;
    logic [3:0] timer_clr;
    logic serial_clr;
    logic [3:0] next_acc;
    logic next_acc_we;
    logic next_breg_we;
    logic next_skip;
    logic d_sel;

    assign go = ce & instr_valid;
    assign in_port = port_of(instr, OP_IN_BASE);
    assign out_port = port_of(instr, OP_OUT_BASE);
    assign timer_skip_en = {~irq_en2[IE2_T4], ~irq_en2[IE2_T3], ~irq_en1[IE1_T2],
                            ~irq_en1[IE1_T1]};
    assign d_sel = bit_port[y_ptr];

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else if (ce) begin
            pin_meta <= {p6_pin, p5_pin, p4_pin, two_bit_pin, three_bit_pin, p1_pin, p0_pin};
            pin_sync <= pin_meta;
        end
    end

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    always_comb begin
        next_acc = acc_in;
        next_acc_we = 1'b0;
        next_breg_we = 1'b0;
        next_skip = 1'b0;
        timer_clr = 4'h0;
        serial_clr = 1'b0;
        if (go) begin
            case (instr)
                OP_SKIP_T1, OP_SKIP_T2, OP_SKIP_T3, OP_SKIP_T4: begin
                    if (timer_skip_en[instr[1:0]] && timer_flag[instr[1:0]]) begin
                        next_skip = 1'b1;
                        timer_clr[instr[1:0]] = 1'b1;
                    end
                end
                OP_TEST_BIT: next_skip = ~d_sel;
                OP_RD_PULL0: begin
                    next_acc = pullup_control_zero;
                    next_acc_we = 1'b1;
                end
                OP_RD_PULL1: begin
                    next_acc = pullup_control_one;
                    next_acc_we = 1'b1;
                end
                OP_RD_KW0: begin
                    next_acc = key_wake_control_zero;
                    next_acc_we = 1'b1;
                end
                OP_RD_KW1: begin
                    next_acc = key_wake_control_one;
                    next_acc_we = 1'b1;
                end
                OP_RD_KW2: begin
                    next_acc = key_wake_control_two;
                    next_acc_we = 1'b1;
                end
                OP_SI_READ: begin
                    next_acc = serial_shift[3:0];
                    next_acc_we = 1'b1;
                    next_breg_we = 1'b1;
                end
                OP_SERIAL_START: serial_clr = 1'b1;
                OP_SERIAL_SKIP: begin
                    if (!irq_en2[IE2_SER] && serial_done_flag) begin
                        next_skip = 1'b1;
                        serial_clr = 1'b1;
                    end
                end
                OP_RD_SCTL: begin
                    next_acc = serial_control_register;
                    next_acc_we = 1'b1;
                end
                OP_RD_MODE: begin
                    next_acc = clock_mode_register;
                    next_acc_we = 1'b1;
                end
                default: begin
                    if (in_port != PORT_NONE) begin
                        next_acc = pin_nibble(in_port, pin_sync);
                        if (in_port == PORT_TWO_BIT) begin
                            next_acc[3:2] = acc_in[3:2];
                        end
                        next_acc_we = 1'b1;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // core answer, one cycle per instruction
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            acc_out <= RST_NIBBLE;
            acc_we <= 1'b0;
            breg_out <= RST_NIBBLE;
            breg_we <= 1'b0;
            skip <= 1'b0;
            serial_start <= 1'b0;
        end else if (ce) begin
            acc_out <= next_acc;
            acc_we <= next_acc_we;
            breg_out <= serial_shift[7:4];
            breg_we <= next_breg_we;
            skip <= next_skip;
            serial_start <= go && (instr == OP_SERIAL_START);
        end
    end

    // ----------------------------------------------------------------
    // event flags, set wins over clear
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            timer_flag <= 4'h0;
            serial_done_flag <= 1'b0;
        end else if (ce) begin
            timer_flag <= timer_event | (timer_flag & ~timer_clr);
            serial_done_flag <= serial_done_event | (serial_done_flag & ~serial_clr);
        end
    end

    // ----------------------------------------------------------------
    // port latches and bit port
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            p0_latch <= RST_NIBBLE;
            p1_latch <= RST_NIBBLE;
            three_bit_port <= RST_NIBBLE[2:0];
            two_bit_port <= RST_NIBBLE[1:0];
            p4_latch <= RST_NIBBLE;
            p5_latch <= RST_NIBBLE;
            p6_latch <= RST_NIBBLE;
        end else if (go) begin
            case (out_port)
                3'h0: p0_latch <= acc_in;
                3'h1: p1_latch <= acc_in;
                3'h2: three_bit_port <= acc_in[2:0];
                3'h3: two_bit_port <= acc_in[1:0];
                3'h4: p4_latch <= acc_in;
                3'h5: p5_latch <= acc_in;
                3'h6: p6_latch <= acc_in;
                default: p0_latch <= p0_latch;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bit_port <= RST_BIT_PORT;
        end else if (go) begin
            if (instr == OP_SET_ALL) begin
                bit_port <= '1;
            end else if (instr == OP_CLR_BIT) begin
                bit_port[y_ptr] <= 1'b0;
            end else if (instr == OP_SET_BIT) begin
                bit_port[y_ptr] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // peripheral control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pullup_control_zero <= RST_NIBBLE;
            pullup_control_one <= RST_NIBBLE;
            key_wake_control_zero <= RST_NIBBLE;
            key_wake_control_one <= RST_NIBBLE;
            key_wake_control_two <= RST_NIBBLE;
            output_format_zero <= RST_NIBBLE;
            output_format_one <= RST_NIBBLE;
            output_format_two <= RST_NIBBLE;
            output_format_three <= RST_NIBBLE;
            serial_control_register <= RST_NIBBLE;
            serial_shift <= RST_SHIFT;
        end else if (go) begin
            case (instr)
                OP_WR_PULL0: pullup_control_zero <= acc_in;
                OP_WR_PULL1: pullup_control_one <= acc_in;
                OP_WR_KW0: key_wake_control_zero <= acc_in;
                OP_WR_KW1: key_wake_control_one <= acc_in;
                OP_WR_KW2: key_wake_control_two <= acc_in;
                OP_WR_FMT0: output_format_zero <= acc_in;
                OP_WR_FMT1: output_format_one <= acc_in;
                OP_WR_FMT2: output_format_two <= acc_in;
                OP_WR_FMT3: output_format_three <= acc_in;
                OP_WR_SCTL: serial_control_register <= acc_in;
                OP_SI_WRITE: serial_shift <= {breg_in, acc_in};
                default: serial_shift <= serial_shift;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            clock_select <= ITSE_CLK_CERAMIC;
            clock_control_bit_register <= 1'b0;
            clock_mode_register <= RST_NIBBLE;
        end else if (go) begin
            case (instr)
                OP_SEL_CERAMIC: clock_select <= ITSE_CLK_CERAMIC;
                OP_SEL_RC: clock_select <= ITSE_CLK_RC;
                OP_SEL_CRYSTAL: clock_select <= ITSE_CLK_CRYSTAL;
                OP_WR_CCB: clock_control_bit_register <= acc_in[0];
                OP_WR_MODE: clock_mode_register <= acc_in;
                default: clock_mode_register <= clock_mode_register;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // avalon slave: one wait cycle, then answer
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= '0;
        end else if (ce) begin
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                avs_readdata <= '0;
                if (avs_address == ADDR_IRQ_EN) begin
                    avs_readdata[7:0] <= {irq_en2, irq_en1};
                end else if (avs_address == ADDR_STATUS) begin
                    avs_readdata[STAT_F_SER:0] <= {serial_done_flag, timer_flag};
                end else if (avs_address == ADDR_CLOCK) begin
                    avs_readdata[CLK_F_MODE+3:0] <= {clock_mode_register, 1'b0,
                                                     clock_control_bit_register, clock_select};
                end else if (avs_address == ADDR_BIT_PORT) begin
                    avs_readdata[7:0] <= bit_port;
                end
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_en1 <= RST_NIBBLE;
            irq_en2 <= RST_NIBBLE;
        end else if (ce && avs_write && !avs_waitrequest && avs_address == ADDR_IRQ_EN) begin
            irq_en1 <= avs_writedata[3:0];
            irq_en2 <= avs_writedata[7:4];
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    timer_one_skip_a: assert property (
        go && instr == OP_SKIP_T1 && !irq_en1[IE1_T1] && timer_flag[0] && !timer_event[0]
        |=> skip && !timer_flag[0])
        else $error("timer one skip did not skip and clear");
    timer_two_nop_a: assert property (
        go && instr == OP_SKIP_T2 && irq_en1[IE1_T2] |=> !skip)
        else $error("timer two skip acted while enabled");
    timer_three_skip_a: assert property (
        go && instr == OP_SKIP_T3 && !irq_en2[IE2_T3] |=> skip == $past(timer_flag[2]))
        else $error("timer three skip wrong");
    timer_four_skip_a: assert property (
        go && instr == OP_SKIP_T4 && !irq_en2[IE2_T4] && timer_flag[3] && !timer_event[3]
        |=> skip && !timer_flag[3])
        else $error("timer four skip did not skip and clear");
    port_three_in_a: assert property (
        go && instr == OP_IN_BASE + 10'h2
        |=> acc_we && acc_out == {1'b0, $past(pin_sync[10:8])})
        else $error("three-bit port input wrong");
    port_two_out_a: assert property (
        go && instr == OP_OUT_BASE + 10'h3 |=> two_bit_port == $past(acc_in[1:0]))
        else $error("two-bit port output wrong");
    set_all_a: assert property (
        go && instr == OP_SET_ALL |=> bit_port == 8'hFF)
        else $error("set all left a line low");
    bit_test_a: assert property (
        go && instr == OP_TEST_BIT |=> skip == !$past(d_sel))
        else $error("bit test skip wrong");
    shift_write_a: assert property (
        go && instr == OP_SI_WRITE ##1 !go ##1 go && instr == OP_SI_READ
        |=> acc_out == $past(acc_in, 3) && breg_out == $past(breg_in, 3) && breg_we)
        else $error("shift register round trip wrong");
    serial_start_a: assert property (
        go && instr == OP_SERIAL_START && !serial_done_event
        |=> serial_start && !serial_done_flag)
        else $error("serial start did not clear flag");
    ccb_write_a: assert property (
        go && instr == OP_WR_CCB |=> clock_control_bit_register == $past(acc_in[0]))
        else $error("clock control bit not loaded");
    bus_answer_a: assert property (
        ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus did not answer after one wait cycle");

endmodule : itse_core

`default_nettype wire

/* sim/itse_peer.sv */
/* Far-side model: timer and serial flag pulses and port pin levels.
   Assumes the bench raises one pulse request at a time. */
`default_nettype none
module itse_peer (
    input wire logic [4:0] fire,
    input wire logic [3:0] pv,
    output logic [3:0] timer_event,
    output logic serial_done_event,
    output logic [27:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // pulses and distinct levels per port
    // ----------------------------------------
    assign {serial_done_event, timer_event} = fire;
    for (genvar n = 0; n < 7; n++) begin : g_pin
        assign pins[4*n+:4] = pv ^ 4'(n);
    end
endmodule : itse_peer
`default_nettype wire

/* sim/tb_io_timer_serial_instr_exec.sv */
/* Bench: instruction and bus tasks, expected values per operation.
   Assumes itse_pkg, itse_core and itse_peer are compiled first. */
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
    $display("BAD %0t %h %h", $time, a, b); end end
module tb_io_timer_serial_instr_exec import itse_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, resetn = 0, instr_valid = 0, avs_read = 0, avs_write = 0;
    logic skip, serial_start, serial_done_event, ccb, avs_waitrequest, awe, bwe;
    logic [9:0] instr = 0;
    logic [3:0] acc_in = 0, breg_in = 0, avs_address = 0, acc_out, breg_out, timer_event;
    logic [2:0] y_ptr = 0;
    logic [4:0] fire = 0;
    logic [1:0] sel;
    logic [7:0] bit_port, serial_shift;
    logic [31:0] avs_writedata = 0, avs_readdata, rd;
    logic [27:0] pp;
    wire [3:0] lat [7];
    wire [3:0] f [4];
    wire [3:0] rg [7];
    assign lat[2][3] = 1'h0, lat[3][3:2] = 2'h0;
    int n_fail = 0, cmp_count = 0, cyc = 0;
    logic [9:0] wr_ops [7] = '{OP_WR_PULL0, OP_WR_PULL1, OP_WR_KW0, OP_WR_KW1, OP_WR_KW2,
        OP_WR_SCTL, OP_WR_MODE};
    logic [9:0] rd_ops [7] = '{OP_RD_PULL0, OP_RD_PULL1, OP_RD_KW0, OP_RD_KW1, OP_RD_KW2,
        OP_RD_SCTL, OP_RD_MODE};
    logic [9:0] clk_ops [3] = '{OP_SEL_CRYSTAL, OP_SEL_RC, OP_SEL_CERAMIC};
    itse_peer i_peer (.fire, .pv(4'h9), .timer_event, .serial_done_event, .pins(pp));
    itse_core i_dut (.clock, .resetn, .ce(1'b1), .instr_valid, .instr, .acc_in, .breg_in,
        .y_ptr, .timer_event, .serial_done_event, .p0_pin(pp[3:0]), .p1_pin(pp[7:4]),
        .three_bit_pin(pp[10:8]), .two_bit_pin(pp[13:12]), .p4_pin(pp[19:16]),
        .p5_pin(pp[23:20]), .p6_pin(pp[27:24]), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .acc_out, .acc_we(awe), .breg_out,
        .breg_we(bwe), .skip, .serial_start, .p0_latch(lat[0]), .p1_latch(lat[1]),
        .three_bit_port(lat[2][2:0]), .two_bit_port(lat[3][1:0]), .p4_latch(lat[4]),
        .p5_latch(lat[5]), .p6_latch(lat[6]), .bit_port, .pullup_control_zero(rg[0]),
        .pullup_control_one(rg[1]), .key_wake_control_zero(rg[2]),
        .key_wake_control_one(rg[3]), .key_wake_control_two(rg[4]), .output_format_zero(f[0]),
        .output_format_one(f[1]), .output_format_two(f[2]), .output_format_three(f[3]),
        .serial_shift, .serial_control_register(rg[5]), .clock_select(sel),
        .clock_control_bit_register(ccb), .clock_mode_register(rg[6]));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    task automatic ex(input logic [9:0] op, input logic [3:0] a = 4'h0, b = 4'h0,
        input logic [2:0] y = 3'h0);
        @(posedge clock);
        {instr, acc_in, breg_in, y_ptr, instr_valid} <= {op, a, b, y, 1'b1};
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
    endtask : ex
    task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
        @(posedge clock);
        {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, ad, d};
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
    endtask : bus
    task automatic pulse(input int i);
        @(posedge clock);
        fire <= 5'(1 << i);
        @(posedge clock);
        fire <= 5'h00;
    endtask : pulse
    always #50 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc > 2000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        logic [9:0] op;
        logic [3:0] e, m;
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        bus(0, ADDR_STATUS, 0);
        `CHK(rd, 32'h0)
        for (int i = 0; i < 5; i++) begin
            op = i < 4 ? OP_SKIP_T1 + 10'(i) : OP_SERIAL_SKIP;
            pulse(i);
            ex(op);
            `CHK(skip, 1'b1)
            ex(op);
            `CHK(skip, 1'b0)
            bus(1, ADDR_IRQ_EN, 32'(1) << (i < 4 ? 2 + i : 7));
            pulse(i);
            ex(op);
            `CHK(skip, 1'b0)
            bus(1, ADDR_IRQ_EN, 0);
            ex(op);
            `CHK(skip, 1'b1)
        end
        pulse(4);
        ex(OP_SERIAL_START);
        `CHK(serial_start, 1'b1)
        ex(OP_SERIAL_SKIP);
        `CHK(skip, 1'b0)
        for (int p = 0; p < 7; p++) begin
            e = 4'h9 ^ 4'(p);
            m = p == 2 ? 4'h7 : p == 3 ? 4'h3 : 4'hF;
            ex(OP_IN_BASE + 10'(p), 4'hF);
            `CHK(acc_out, (e & m) | (p == 3 ? 4'hC : 4'h0))
            ex(OP_OUT_BASE + 10'(p), 4'hD);
            `CHK(lat[p] & m, 4'hD & m)
        end
        ex(OP_SET_ALL);
        `CHK(bit_port, 8'hFF)
        for (int y = 0; y < 8; y++) begin
            ex(OP_CLR_BIT, 0, 0, 3'(y));
            `CHK(bit_port, ~(8'h01 << y))
            ex(OP_TEST_BIT, 0, 0, 3'(y));
            `CHK(skip, 1'b1)
            ex(OP_TEST_BIT, 0, 0, 3'(y ^ 1));
            `CHK(skip, 1'b0)
            ex(OP_SET_BIT, 0, 0, 3'(y));
            `CHK(bit_port, 8'hFF)
        end
        for (int r = 0; r < 7; r++) ex(wr_ops[r], 4'(r + 9));
        for (int r = 0; r < 7; r++) begin
            ex(rd_ops[r]);
            `CHK(acc_out, 4'(r + 9))
            `CHK(rg[r], 4'(r + 9))
        end
        for (int k = 0; k < 4; k++) ex(OP_WR_FMT0 + 10'(k), 4'(k + 3));
        `CHK({f[3], f[2], f[1], f[0]}, 16'h6543)
        ex(OP_SI_WRITE, 4'h3, 4'hC);
        `CHK(serial_shift, 8'hC3)
        ex(OP_SI_READ);
        `CHK({bwe, awe, breg_out, acc_out}, 10'h3C3)
        for (int k = 0; k < 3; k++) begin
            ex(clk_ops[k]);
            `CHK(sel, 2'(2 - k))
        end
        ex(OP_WR_CCB, 4'hF);
        `CHK(ccb, 1'b1)
        ex(OP_WR_CCB, 4'hE);
        `CHK(ccb, 1'b0)
        bus(0, ADDR_CLOCK, 0);
        `CHK(rd, 32'h000000F0)
        bus(0, 4'h1, 0);
        `CHK(rd, 32'h0)
        tally_and_finish();
    end
endmodule : tb_io_timer_serial_instr_exec
`default_nettype wire
